/* File: core/pdmw_core.sv */
`timescale 1ns/100ps
`default_nettype none
module pdmw_core
  import pdmw_pkg::*;
#(
  parameter int WDT_WIDTH = 16
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sleep_op,
  input  wire logic        clr_wdt_op,
  input  wire logic        wdt_enable,
  input  wire logic        ext_reset_pin,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic        portb_wr,
  input  wire logic [7:0]  mode_reg,
  input  wire logic [7:0]  w_data,
  output logic [7:0]       xchg_data_q,
  output logic [7:0]       pin_dir_q,
  output logic [7:0]       wakeup_enable_mask_q,
  output logic [7:0]       wakeup_edge_select_q,
  output logic [7:0]       wakeup_pending_latch_q,
  output logic             time_out_flag_q,
  output logic             power_down_flag_q,
  output logic             core_run,
  output logic             portb_irq,
  output logic             pc_load_q,
  output logic [10:0]      pc_value,
  output pdmw_wake_t       wake_cause_q
);

  logic [7:0]           sync1_q;
  logic [7:0]           sync2_q;
  logic [7:0]           prev_q;
  logic [7:0]           edge_hit;
  logic [7:0]           armed_hit;
  logic                 wdt_ovf;
  logic [WDT_WIDTH-1:0] wdt_q;
  logic [WDT_WIDTH-1:0] wdt_d;
  pdmw_state_t          state_q;
  pdmw_state_t          state_d;
  logic [7:0]           en_d;
  logic [7:0]           edge_d;
  logic [7:0]           dir_d;
  logic [7:0]           pend_d;
  logic [7:0]           xchg_d;
  logic                 to_d;
  logic                 pd_d;
  logic                 pc_load_d;
  pdmw_wake_t           cause_d;
  logic                 pend_seen_q; // pending latch written since reset
  logic                 pend_seen_d;

  // detect a selected edge on pin b
  function automatic logic [7:0] sel_edge(input logic [7:0] cur,
                                          input logic [7:0] old,
                                          input logic [7:0] sel);
    sel_edge = (sel & old & ~cur) | (~sel & ~old & cur);
  endfunction : sel_edge

  // pin synchroniser and history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q  <= 8'h00;
    end else begin
      sync1_q <= port_b_pins;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // shared edge logic for wake and interrupt
  // sampled edge compare
  always_comb begin
    edge_hit  = sel_edge(sync2_q, prev_q, wakeup_edge_select_q);
    armed_hit = wakeup_pending_latch_q & ~wakeup_enable_mask_q;
    wdt_ovf   = wdt_enable && (&wdt_q);
  end

  assign portb_irq = (state_q == PDMW_ST_RUN) && (|armed_hit);
  assign core_run  = (state_q == PDMW_ST_RUN);
  assign pc_value  = PDMW_PC_TOP;

  // port b control writes and pending latch next values
  always_comb begin
    en_d   = wakeup_enable_mask_q;
    edge_d = wakeup_edge_select_q;
    dir_d  = pin_dir_q;
    pend_d = wakeup_pending_latch_q;
    xchg_d = xchg_data_q;
    pend_seen_d = pend_seen_q;
    if (portb_wr) begin
      unique case (mode_reg)
        PDMW_MODE_EDGE: edge_d = w_data;
        PDMW_MODE_EN:   en_d   = w_data;
        PDMW_MODE_DIR:  dir_d  = w_data;
        PDMW_MODE_PEND: begin
          pend_d = w_data;
          xchg_d = wakeup_pending_latch_q;
          pend_seen_d = 1'b1;
        end
        default: ;
      endcase
    end
    pend_d = pend_d | edge_hit;
  end

  // configuration registers
  // enable, edge and direction reset to all ones, exchange data to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_enable_mask_q <= PDMW_EN_RST;
      wakeup_edge_select_q <= PDMW_EDGE_RST;
      pin_dir_q            <= PDMW_DIR_RST;
      xchg_data_q          <= 8'h00;
      pend_seen_q          <= 1'b0;
    end else begin
      wakeup_enable_mask_q <= en_d;
      wakeup_edge_select_q <= edge_d;
      pin_dir_q            <= dir_d;
      xchg_data_q          <= xchg_d;
      pend_seen_q          <= pend_seen_d;
    end
  end

  always_ff @(posedge clock) begin
    wakeup_pending_latch_q <= pend_d;
  end

  // power state, watchdog and status flags
  always_comb begin
    state_d   = state_q;
    wdt_d     = wdt_enable ? wdt_q + 1'b1 : wdt_q;
    to_d      = time_out_flag_q;
    pd_d      = power_down_flag_q;
    pc_load_d = 1'b0;
    cause_d   = wake_cause_q;
    if (wdt_ovf) begin
      to_d = PDMW_FLAG_CLR;
    end
    if (clr_wdt_op && state_q == PDMW_ST_RUN) begin
      wdt_d = '0;
      to_d  = PDMW_FLAG_SET;
      pd_d  = PDMW_FLAG_SET;
    end
    unique case (state_q)
      PDMW_ST_RUN: begin
        if (sleep_op) begin
          state_d = PDMW_ST_SLEEP;
          wdt_d   = '0;
          to_d    = PDMW_FLAG_SET;
          pd_d    = PDMW_FLAG_CLR;
        end
      end
      PDMW_ST_SLEEP: begin
        if (ext_reset_pin || wdt_ovf || (|armed_hit)) begin
          state_d   = PDMW_ST_RUN;
          cause_d   = '{by_wdt: wdt_ovf, by_pin: |armed_hit, by_ext: ext_reset_pin};
          pc_load_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q           <= PDMW_ST_RUN;
      wdt_q             <= '0;
      time_out_flag_q   <= PDMW_FLAG_SET;
      power_down_flag_q <= PDMW_FLAG_SET;
      pc_load_q         <= 1'b0;
      wake_cause_q      <= '0;
    end else begin
      state_q           <= state_d;
      wdt_q             <= wdt_d;
      time_out_flag_q   <= to_d;
      power_down_flag_q <= pd_d;
      pc_load_q         <= pc_load_d;
      wake_cause_q      <= cause_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_asleep;
    state_q == PDMW_ST_SLEEP;
  endsequence
  sequence s_pin_wake;
    s_asleep ##0 (|armed_hit) ##1 (state_q == PDMW_ST_RUN);
  endsequence

  chk_sleep_entry_only: assert property (
    $rose(state_q == PDMW_ST_SLEEP) |-> $past(sleep_op))
    else $error("power-down entered without sleep instruction");
  chk_core_halted: assert property (
    s_asleep |-> !core_run && !portb_irq)
    else $error("core running while asleep");
  chk_sleep_flags: assert property (
    (state_q == PDMW_ST_RUN && sleep_op)
      |=> time_out_flag_q && !power_down_flag_q && (wdt_q == '0))
    else $error("sleep entry flags wrong");
  chk_wake_sources: assert property (
    $fell(state_q == PDMW_ST_SLEEP)
      |-> $past(ext_reset_pin) || $past(wdt_ovf) || $past(|armed_hit))
    else $error("wake without valid source");
  chk_disarmed_quiet: assert property (
    (wakeup_enable_mask_q == PDMW_EN_RST) |-> !portb_irq)
    else $error("disarmed pins raised interrupt");
  chk_edge_latched: assert property (
    (|edge_hit) |=> ((wakeup_pending_latch_q & $past(edge_hit)) == $past(edge_hit)))
    else $error("selected edge not latched");
  chk_pin_wake_pc: assert property (
    s_pin_wake |-> pc_load_q && pc_value == PDMW_PC_TOP)
    else $error("pin wake did not load top address");
  chk_pend_swap: assert property (
    (portb_wr && mode_reg == PDMW_MODE_PEND && !(|edge_hit) && pend_seen_q)
      |=> xchg_data_q == $past(wakeup_pending_latch_q)
          && wakeup_pending_latch_q == $past(w_data))
    else $error("pending exchange wrong");
  chk_edge_write: assert property (
    (portb_wr && mode_reg == PDMW_MODE_EDGE) |=> wakeup_edge_select_q == $past(w_data))
    else $error("edge select write lost");
  chk_timeout_clear: assert property (
    (wdt_ovf && !sleep_op && !clr_wdt_op) |=> !time_out_flag_q)
    else $error("time-out flag not cleared on overflow");

endmodule : pdmw_core
`default_nettype wire

/* File: inc/pdmw_pkg.sv */
// shared constants and types for power-down and multi-input wakeup
package pdmw_pkg;
  localparam logic [7:0]  PDMW_MODE_DIR   = 8'h0F; // pin direction select
  localparam logic [7:0]  PDMW_MODE_EDGE  = 8'h0A; // edge select register
  localparam logic [7:0]  PDMW_MODE_PEND  = 8'h09; // pending latch (exchange)
  localparam logic [7:0]  PDMW_MODE_EN    = 8'h0B; // enable mask register
  localparam logic [7:0]  PDMW_EN_RST     = 8'hFF; // all pins disarmed
  localparam logic [7:0]  PDMW_EDGE_RST   = 8'hFF; // all pins falling edge
  localparam logic [7:0]  PDMW_DIR_RST    = 8'hFF; // all pins inputs
  localparam logic [10:0] PDMW_PC_TOP     = 11'h7FF; // reset program address
  localparam logic        PDMW_FLAG_SET   = 1'b1;
  localparam logic        PDMW_FLAG_CLR   = 1'b0;

  // run state of the core
  typedef enum logic {
    PDMW_ST_RUN,
    PDMW_ST_SLEEP
  } pdmw_state_t;

  // cause of the last exit from power-down
  typedef struct packed {
    logic by_wdt;
    logic by_pin;
    logic by_ext;
  } pdmw_wake_t;
endpackage : pdmw_pkg

/* File: testbench/pdmw_pins_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far side: port b pin levels and the external reset line
module pdmw_pins_model (
  input  wire logic       clock,
  output logic [7:0]      port_b_pins,
  output logic            ext_reset_pin
);
  // pins idle high, no reset request
  initial begin
    port_b_pins   = 8'hFF;
    ext_reset_pin = 1'b0;
  end
  // new level after a falling edge, then time for sync and compare
  task automatic set_pins(input logic [7:0] v);
    @(negedge clock);
    port_b_pins = v;
    repeat (4) @(negedge clock);
  endtask : set_pins
  task automatic set_ext(input logic v);
    @(negedge clock);
    ext_reset_pin = v;
  endtask : set_ext
endmodule : pdmw_pins_model
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pdmw_pkg::*;
  logic        clock      = 1'b0;
  logic        rst_n;
  logic        sleep_op;
  logic        clr_wdt_op;
  logic        wdt_enable;
  logic        portb_wr;
  logic [7:0]  mode_reg;
  logic [7:0]  w_data;
  logic [7:0]  port_b_pins, xchg_data_q, pin_dir_q, en_q, edge_q, pend_q;
  logic        ext_reset_pin, to_q, pd_q, core_run, portb_irq, pc_load_q;
  logic [10:0] pc_value;
  pdmw_wake_t  wake_cause_q;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  pdmw_core #(.WDT_WIDTH(4)) u_pdmw_core (.clock(clock), .rst_n(rst_n),
    .sleep_op(sleep_op), .clr_wdt_op(clr_wdt_op), .wdt_enable(wdt_enable),
    .ext_reset_pin(ext_reset_pin), .port_b_pins(port_b_pins), .portb_wr(portb_wr),
    .mode_reg(mode_reg), .w_data(w_data), .xchg_data_q(xchg_data_q),
    .pin_dir_q(pin_dir_q), .wakeup_enable_mask_q(en_q), .wakeup_edge_select_q(edge_q),
    .wakeup_pending_latch_q(pend_q), .time_out_flag_q(to_q), .power_down_flag_q(pd_q),
    .core_run(core_run), .portb_irq(portb_irq), .pc_load_q(pc_load_q),
    .pc_value(pc_value), .wake_cause_q(wake_cause_q));
  pdmw_pins_model u_pdmw_pins_model (.clock(clock), .port_b_pins(port_b_pins),
    .ext_reset_pin(ext_reset_pin));
  // 4 ns clock
  always #2 clock = ~clock;
  // compare one value and count it
  task automatic check(input string name, input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // port b control write, one cycle strobe
  task automatic wr(input logic [7:0] mode, input logic [7:0] data);
    @(negedge clock);
    portb_wr = 1'b1;
    mode_reg = mode;
    w_data   = data;
    @(negedge clock);
    portb_wr = 1'b0;
  endtask : wr
  // sleep instruction, then flags and run state
  task automatic do_sleep();
    @(negedge clock);
    sleep_op = 1'b1;
    @(negedge clock);
    sleep_op = 1'b0;
    check("core_run", 11'(core_run), 11'h000);
    check("pd_flag", 11'(pd_q), 11'h000);
    check("to_flag", 11'(to_q), 11'h001);
  endtask : do_sleep
  // bounded wait for wake, then program counter load and cause
  task automatic wait_wake(input logic [2:0] cause);
    int n;
    n = 0;
    while (core_run !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check("pc_load", 11'(pc_load_q), 11'h001);
    check("pc_value", pc_value, PDMW_PC_TOP);
    check("wake_cause", {8'h00, wake_cause_q}, {8'h00, cause});
  endtask : wait_wake
  // verdict
  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  // main sequence
  initial begin
    rst_n      = 1'b0;
    sleep_op   = 1'b0;
    clr_wdt_op = 1'b0;
    wdt_enable = 1'b0;
    portb_wr   = 1'b0;
    mode_reg   = 8'h00;
    w_data     = 8'h00;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    check("en_rst", 11'(en_q), 11'h0FF);
    check("edge_rst", 11'(edge_q), 11'h0FF);
    check("flags_rst", 11'({to_q, pd_q}), 11'h003);
    wr(8'h00, 8'h00);
    check("bad_mode", 11'(en_q), 11'h0FF);
    wr(PDMW_MODE_DIR, 8'h07);
    check("dir", 11'(pin_dir_q), 11'h007);
    wr(PDMW_MODE_EDGE, 8'h0F);
    check("edge", 11'(edge_q), 11'h00F);
    wr(PDMW_MODE_PEND, 8'h00);
    check("pend_clr", 11'(pend_q), 11'h000);
    u_pdmw_pins_model.set_pins(8'hFE);
    u_pdmw_pins_model.set_pins(8'hEE);
    u_pdmw_pins_model.set_pins(8'hFE);
    check("pend_edges", 11'(pend_q), 11'h011);
    check("irq_off", 11'(portb_irq), 11'h000);
    wr(PDMW_MODE_PEND, 8'h00);
    check("xchg", 11'(xchg_data_q), 11'h011);
    check("pend_swap", 11'(pend_q), 11'h000);
    wr(PDMW_MODE_EN, 8'hFE);
    check("en", 11'(en_q), 11'h0FE);
    u_pdmw_pins_model.set_pins(8'hFF);
    u_pdmw_pins_model.set_pins(8'hFE);
    check("pend_arm", 11'(pend_q), 11'h001);
    check("irq_on", 11'(portb_irq), 11'h001);
    wr(PDMW_MODE_PEND, 8'h00);
    u_pdmw_pins_model.set_pins(8'hFF);
    do_sleep();
    u_pdmw_pins_model.set_pins(8'hFE);
    wait_wake(3'b010);
    wr(PDMW_MODE_PEND, 8'h00);
    do_sleep();
    u_pdmw_pins_model.set_ext(1'b1);
    wait_wake(3'b001);
    u_pdmw_pins_model.set_ext(1'b0);
    wdt_enable = 1'b1;
    do_sleep();
    wait_wake(3'b100);
    check("to_wdt", 11'(to_q), 11'h000);
    // clear-watchdog instruction sets both flags again
    @(negedge clock);
    clr_wdt_op = 1'b1;
    @(negedge clock);
    clr_wdt_op = 1'b0;
    check("clr_flags", 11'({to_q, pd_q}), 11'h003);
    // reset in mid-run while asleep restores masks and flags
    do_sleep();
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    check("en_rst2", 11'(en_q), 11'h0FF);
    check("edge_rst2", 11'(edge_q), 11'h0FF);
    check("flags_rst2", 11'({to_q, pd_q}), 11'h003);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
